// *** hdl/line_if.sv ***
// synchronised serial line levels and conditions, from the line sampler to the control core
// assumes both ends run on ref_clk
`timescale 1ns/100ps
interface line_if;
  logic sda_lvl;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  modport src (output sda_lvl, scl_rise, scl_fall, start_det, stop_det);
  modport dst (input sda_lvl, scl_rise, scl_fall, start_det, stop_det);
endinterface

// *** hdl/line_sampler.sv ***
// two-flop synchroniser and edge / start / stop detection for the serial clock and data pins
// assumes pins are asynchronous to ref_clk and far slower than it
`timescale 1ns/100ps
module line_sampler (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic scl_i,
  input wire logic sda_i,
  line_if.src ln
);
  typedef struct packed {
    logic [1:0] meta;
    logic [1:0] sync;
    logic [1:0] prev;
  } samp_t;
  samp_t q, d;

  always_comb begin
    d = q;
    d.meta = {scl_i, sda_i};
    d.sync = q.meta;
    d.prev = q.sync;
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      q <= '{meta: 2'h3, sync: 2'h3, prev: 2'h3};
    end else begin
      q <= d;
    end
  end

  assign ln.sda_lvl = q.sync[0];
  assign ln.scl_rise = q.sync[1] & ~q.prev[1];
  assign ln.scl_fall = ~q.sync[1] & q.prev[1];
  // data moving while the clock stays high marks a bus condition
  assign ln.start_det = q.sync[1] & q.prev[1] & ~q.sync[0] & q.prev[0];
  assign ln.stop_det = q.sync[1] & q.prev[1] & q.sync[0] & ~q.prev[0];
endmodule // line_sampler

// *** hdl/serial0_ctrl.sv ***
// serial interface 0 control and status: wait, acknowledge, clock count, interrupt point, shift rate
// assumes a 125 MHz ref_clk, register port strobes on ref_clk, clock_stop_rst and ce_rst synchronous
// Functional notes
// - The wait timing field picks no wait, a wait after 8 clocks, after 9 clocks, or the bus-mode 8-clock wait.
// - Writing the wait inhibit bit to 0 allows waits and writing it to 1 suppresses them.
// - In bus mode software sets the acknowledge level driven and reads back the level seen from the peer.
// - The wait status bit reads 0 while waiting and 1 while a transfer runs.
// - The eighth-clock flag sets when the clock count is 8 and clears when it is 0 or 1.
// - The ninth-clock flag sets when the clock count is 9 and clears when it is 0 or 1.
// - In bus mode the start-phase flag holds from a start condition to the ninth clock of the next byte.
// - In bus mode the bus-busy flag holds from a start condition to the next stop condition.
// - The interrupt point selects 7th clock, 8th clock, 7th clock after start, or stop condition.
// - The shift rate field gives 37.5, 75, 112.5 or 225 kHz and survives clock stop.
// - Two mode bits choose two-wire, bus or three-wire operation, with one combination prohibited.
// - The clock direction bit chooses the external clock at 0 and the internal clock at 1.
`timescale 1ns/100ps
module serial0_ctrl (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic clock_stop_rst,
  input wire logic ce_rst,
  input wire logic [serial0_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [serial0_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [serial0_pkg::DATA_W-1:0] reg_rdata,
  output logic irq,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe
);
  import serial0_pkg::*;

  typedef struct packed {
    logic [3:0] mode;
    logic [3:0] wait_ctl;
    logic ack_seen;
    logic [1:0] irq_point;
    logic [1:0] shift_rate;
    logic [3:0] cnt;
    logic eighth_clock_flag;
    logic ninth_clock_flag;
    logic start_phase_flag;
    logic bus_busy_flag;
    logic waiting;
    logic xfer;
    logic ack_win;
    logic [HALF_W-1:0] div;
    logic scl_gen;
    logic [3:0] ev_status;
    logic [3:0] ev_mask;
    logic [3:0] rdata;
    logic irq;
    logic scl_o;
    logic scl_oe;
    logic sda_oe;
  } ctrl_t;

  ctrl_t q, d;
  line_if ln ();

  line_sampler u_sampler (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .ln(ln)
  );

  logic bus;
  logic active;
  logic internal;
  logic rise;
  logic fall;
  logic [3:0] lim;
  logic [3:0] wait_at;
  logic [HALF_W-1:0] half;
  logic point_ev;
  logic [3:0] ev_set;
  logic wait_entry;

  always_comb begin
    d = q;
    bus = q.mode[BIT_WIRE_COUNT:BIT_BUS_MODE] == MODE_BUS;
    active = q.mode[BIT_WIRE_COUNT:BIT_BUS_MODE] != MODE_PROHIBITED;
    internal = q.mode[BIT_CLOCK_DIR];
    rise = ln.scl_rise & active;
    fall = ln.scl_fall & active;
    lim = bus ? CNT_9 : CNT_8;
    wait_entry = 1'b0;
    case (q.shift_rate)
      2'h0: half = HALF_0;
      2'h1: half = HALF_1;
      2'h2: half = HALF_2;
      default: half = HALF_3;
    endcase
    case (q.wait_ctl[1:0])
      WAIT_AFTER_8: wait_at = CNT_8;
      WAIT_AFTER_9: wait_at = CNT_9;
      WAIT_BUS_8: wait_at = bus ? CNT_8 : 4'h0;
      default: wait_at = 4'h0;
    endcase
    // internal shift clock runs only while a transfer is open
    if (internal && active && q.xfer && !q.waiting) begin
      if (q.div == '0) begin
        d.div = half - HALF_W'(1);
        d.scl_gen = ~q.scl_gen;
      end else begin
        d.div = q.div - HALF_W'(1);
      end
    end else begin
      d.div = '0;
      d.scl_gen = 1'b1;
    end
    if (bus && ln.start_det) begin
      d.cnt = 4'h0;
    end else if (rise) begin
      d.cnt = (q.cnt >= lim) ? 4'h1 : q.cnt + 4'h1;
      d.xfer = ~q.waiting;
    end
    // flags hold between the set and clear counts
    if (q.cnt == CNT_8) begin
      d.eighth_clock_flag = 1'b1;
    end else if (q.cnt <= 4'h1) begin
      d.eighth_clock_flag = 1'b0;
    end
    if (q.cnt == CNT_9) begin
      d.ninth_clock_flag = 1'b1;
    end else if (q.cnt <= 4'h1) begin
      d.ninth_clock_flag = 1'b0;
    end
    if (!bus) begin
      d.start_phase_flag = 1'b0;
      d.bus_busy_flag = 1'b0;
    end else begin
      if (ln.start_det) begin
        d.start_phase_flag = 1'b1;
      end else if (rise && q.cnt == CNT_8) begin
        d.start_phase_flag = 1'b0;
      end
      if (ln.start_det) begin
        d.bus_busy_flag = 1'b1;
      end else if (ln.stop_det) begin
        d.bus_busy_flag = 1'b0;
      end
    end
    if (bus && rise && q.cnt == CNT_8) begin
      d.ack_seen = ln.sda_lvl;
    end
    // acknowledge slot spans the low and high phase of the ninth clock
    if (!bus || ln.start_det || ln.stop_det) begin
      d.ack_win = 1'b0;
    end else if (fall && q.cnt == CNT_8) begin
      d.ack_win = 1'b1;
    end else if (fall && q.cnt == CNT_9) begin
      d.ack_win = 1'b0;
    end
    if (fall && !q.wait_ctl[BIT_WAIT_INHIBIT] && wait_at != 4'h0 && q.cnt == wait_at) begin
      d.waiting = 1'b1;
      d.xfer = 1'b0;
      wait_entry = 1'b1;
    end else if (fall && q.cnt == lim) begin
      d.xfer = 1'b0;
    end
    case (q.irq_point)
      IRQ_AT_7: point_ev = rise && q.cnt == CNT_7 - 4'h1;
      IRQ_AT_8: point_ev = rise && q.cnt == CNT_8 - 4'h1;
      IRQ_AT_7_AFTER_START: point_ev = rise && q.cnt == CNT_7 - 4'h1 && q.start_phase_flag;
      default: point_ev = bus && ln.stop_det;
    endcase
    ev_set = '0;
    ev_set[EV_POINT] = point_ev;
    ev_set[EV_WAIT] = wait_entry;
    ev_set[EV_START] = bus && ln.start_det;
    ev_set[EV_STOP] = bus && ln.stop_det;
    if (reg_wr) begin
      case (reg_addr)
        ADDR_MODE: d.mode = reg_wdata;
        ADDR_WAIT_CONTROL: begin
          // writing the wait control word resumes or opens a transfer
          d.wait_ctl = reg_wdata;
          d.waiting = 1'b0;
          d.xfer = 1'b1;
        end
        ADDR_INTERRUPT_POINT: d.irq_point = reg_wdata[1:0];
        ADDR_SHIFT_RATE_SELECT: d.shift_rate = reg_wdata[1:0];
        ADDR_EVENT_MASK: d.ev_mask = reg_wdata;
        default: ;
      endcase
    end
    // a clearing read never loses a same-cycle event
    d.ev_status = ((reg_rd && reg_addr == ADDR_EVENT_STATUS) ? 4'h0 : q.ev_status) | ev_set;
    d.rdata = 4'h0;
    if (reg_rd) begin
      case (reg_addr)
        ADDR_MODE: d.rdata = q.mode;
        ADDR_WAIT_CONTROL: d.rdata = {q.ack_seen, q.wait_ctl[2:0]};
        ADDR_WAIT_STATUS: d.rdata = {3'h0, q.xfer};
        ADDR_CLOCK_COUNT_STATUS: begin
          d.rdata = {q.eighth_clock_flag, q.ninth_clock_flag, q.start_phase_flag, q.bus_busy_flag};
        end
        ADDR_INTERRUPT_POINT: d.rdata = {2'h0, q.irq_point};
        ADDR_SHIFT_RATE_SELECT: d.rdata = {2'h0, q.shift_rate};
        ADDR_EVENT_STATUS: d.rdata = q.ev_status;
        ADDR_EVENT_MASK: d.rdata = q.ev_mask;
        default: d.rdata = 4'h0;
      endcase
    end
    // irq_point, shift_rate and mask survive these resets
    if (clock_stop_rst || ce_rst) begin
      d.mode = RESET_MODE;
      d.wait_ctl = RESET_WAIT_CONTROL;
      d.ack_seen = 1'b0;
      d.xfer = 1'b0;
      d.waiting = 1'b0;
      d.ack_win = 1'b0;
      d.cnt = 4'h0;
      d.eighth_clock_flag = 1'b0;
      d.ninth_clock_flag = 1'b0;
      d.start_phase_flag = 1'b0;
      d.bus_busy_flag = 1'b0;
      d.ev_status = 4'h0;
    end
    d.irq = |(d.ev_status & d.ev_mask);
    // pin drive; the bus is open drain, three-wire internal clock is push-pull
    if (d.waiting) begin
      d.scl_o = 1'b0;
      d.scl_oe = 1'b1;
    end else if (internal && active && d.mode[BIT_WIRE_COUNT]) begin
      d.scl_o = d.scl_gen;
      d.scl_oe = 1'b1;
    end else if (internal && active) begin
      d.scl_o = 1'b0;
      d.scl_oe = ~d.scl_gen;
    end else begin
      d.scl_o = 1'b0;
      d.scl_oe = 1'b0;
    end
    d.sda_oe = d.ack_win & ~d.wait_ctl[BIT_ACK_LEVEL];
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      q <= '0;
      q.scl_gen <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign reg_rdata = q.rdata;
  assign irq = q.irq;
  assign scl_o = q.scl_o;
  assign scl_oe = q.scl_oe;
  assign sda_o = 1'b0;
  assign sda_oe = q.sda_oe;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  sequence s_wait_entered;
    !q.waiting ##1 q.waiting;
  endsequence

  property p_wait_after_8;
    s_wait_entered |-> $past(q.wait_ctl[1:0]) != WAIT_AFTER_8 || $past(q.cnt) == CNT_8;
  endproperty
  a_wait_after_8: assert property (p_wait_after_8) else $error("wait entered off the 8th clock");

  property p_inhibit_blocks;
    q.wait_ctl[BIT_WAIT_INHIBIT] && !q.waiting && !reg_wr |=> !q.waiting;
  endproperty
  a_inhibit_blocks: assert property (p_inhibit_blocks) else $error("wait entered while inhibited");

  property p_wait_status_read;
    reg_rd && reg_addr == ADDR_WAIT_STATUS && q.waiting |=> reg_rdata == 4'h0;
  endproperty
  a_wait_status_read: assert property (p_wait_status_read) else $error("wait status not 0 in wait");

  property p_eighth_flag;
    q.cnt == CNT_8 && !clock_stop_rst && !ce_rst |=> q.eighth_clock_flag;
  endproperty
  a_eighth_flag: assert property (p_eighth_flag) else $error("eighth clock flag missed");

  property p_ninth_clear;
    q.cnt == 4'h1 |=> !q.ninth_clock_flag;
  endproperty
  a_ninth_clear: assert property (p_ninth_clear) else $error("ninth clock flag not cleared");

  sequence s_bus_start;
    bus && ln.start_det && !clock_stop_rst && !ce_rst;
  endsequence

  property p_start_phase;
    s_bus_start |=> q.start_phase_flag && q.bus_busy_flag && q.cnt == 4'h0;
  endproperty
  a_start_phase: assert property (p_start_phase) else $error("start not flagged");

  property p_busy_rise;
    $rose(q.bus_busy_flag) |-> $past(ln.start_det) && $past(bus);
  endproperty
  a_busy_rise: assert property (p_busy_rise) else $error("bus busy without start");

  // pin drive is registered from the next state, so it lines up with q.waiting in the same cycle
  property p_scl_held;
    q.waiting |-> q.scl_oe && !q.scl_o;
  endproperty
  a_scl_held: assert property (p_scl_held) else $error("clock not held low in wait");

  property p_soft_reset;
    clock_stop_rst |=> q.wait_ctl == RESET_WAIT_CONTROL && !q.xfer && !q.bus_busy_flag;
  endproperty
  a_soft_reset: assert property (p_soft_reset) else $error("soft reset left state");

  property p_ninth_flag;
    q.cnt == CNT_9 && !clock_stop_rst && !ce_rst |=> q.ninth_clock_flag;
  endproperty
  a_ninth_flag: assert property (p_ninth_flag) else $error("ninth clock flag missed");

  property p_busy_stop;
    ln.stop_det |=> !q.bus_busy_flag;
  endproperty
  a_busy_stop: assert property (p_busy_stop) else $error("bus busy held past stop");

  property p_ack_drive;
    bus && fall && q.cnt == CNT_8 && !clock_stop_rst && !ce_rst |=> q.sda_oe == !q.wait_ctl[BIT_ACK_LEVEL];
  endproperty
  a_ack_drive: assert property (p_ack_drive) else $error("acknowledge level not driven");

  property p_wait_release;
    reg_wr && reg_addr == ADDR_WAIT_CONTROL && !clock_stop_rst && !ce_rst |=> !q.waiting && q.xfer;
  endproperty
  a_wait_release: assert property (p_wait_release) else $error("wait not released by write");

  sequence s_seventh_rise;
    rise && q.cnt == CNT_7 - 4'h1;
  endsequence

  property p_point_at_7;
    s_seventh_rise ##0 (q.irq_point == IRQ_AT_7 && !clock_stop_rst && !ce_rst) |=> q.ev_status[EV_POINT];
  endproperty
  a_point_at_7: assert property (p_point_at_7) else $error("7th clock event missed");
endmodule // serial0_ctrl

// *** hdl/serial0_pkg.sv ***
// serial interface 0 control package: register map, field layout, reset values, timing
// assumes a 125 MHz reference clock and a 6-bit register address with 4-bit data
package serial0_pkg;
  localparam int ADDR_W = 6;
  localparam int DATA_W = 4;
  localparam logic [ADDR_W-1:0] ADDR_MODE = 6'h08;
  localparam logic [ADDR_W-1:0] ADDR_WAIT_CONTROL = 6'h18;
  localparam logic [ADDR_W-1:0] ADDR_WAIT_STATUS = 6'h19;
  localparam logic [ADDR_W-1:0] ADDR_CLOCK_COUNT_STATUS = 6'h28;
  localparam logic [ADDR_W-1:0] ADDR_INTERRUPT_POINT = 6'h38;
  localparam logic [ADDR_W-1:0] ADDR_SHIFT_RATE_SELECT = 6'h39;
  localparam logic [ADDR_W-1:0] ADDR_EVENT_STATUS = 6'h3a;
  localparam logic [ADDR_W-1:0] ADDR_EVENT_MASK = 6'h3b;
  // wait control field positions
  localparam int BIT_ACK_LEVEL = 3;
  localparam int BIT_WAIT_INHIBIT = 2;
  // mode field positions
  localparam int BIT_WIRE_COUNT = 3;
  localparam int BIT_BUS_MODE = 2;
  localparam int BIT_CLOCK_DIR = 1;
  // {wire_count_select, bus_mode_select}
  localparam logic [1:0] MODE_TWO_WIRE = 2'h0;
  localparam logic [1:0] MODE_BUS = 2'h1;
  localparam logic [1:0] MODE_THREE_WIRE = 2'h2;
  localparam logic [1:0] MODE_PROHIBITED = 2'h3;
  // wait timing codes
  localparam logic [1:0] WAIT_NONE = 2'h0;
  localparam logic [1:0] WAIT_AFTER_8 = 2'h1;
  localparam logic [1:0] WAIT_AFTER_9 = 2'h2;
  localparam logic [1:0] WAIT_BUS_8 = 2'h3;
  // interrupt point codes
  localparam logic [1:0] IRQ_AT_7 = 2'h0;
  localparam logic [1:0] IRQ_AT_8 = 2'h1;
  localparam logic [1:0] IRQ_AT_7_AFTER_START = 2'h2;
  localparam logic [1:0] IRQ_AT_STOP = 2'h3;
  // event status bits
  localparam int EV_POINT = 0;
  localparam int EV_WAIT = 1;
  localparam int EV_START = 2;
  localparam int EV_STOP = 3;
  localparam logic [3:0] CNT_7 = 4'h7;
  localparam logic [3:0] CNT_8 = 4'h8;
  localparam logic [3:0] CNT_9 = 4'h9;
  localparam logic [3:0] RESET_WAIT_CONTROL = 4'h0;
  localparam logic [3:0] RESET_MODE = 4'h0;
  localparam logic [1:0] RESET_INTERRUPT_POINT = 2'h0;
  localparam logic [1:0] RESET_SHIFT_RATE = 2'h0;
  localparam logic [3:0] RESET_EVENT_MASK = 4'h0;
  // shift clock timing
  localparam int REF_CLK_HZ = 125000000;
  localparam int RATE_0_HZ = 37500;
  localparam int RATE_1_HZ = 75000;
  localparam int RATE_2_HZ = 112500;
  localparam int RATE_3_HZ = 225000;
  localparam int HALF_W = 11;
  localparam logic [HALF_W-1:0] HALF_0 = HALF_W'(REF_CLK_HZ / (2 * RATE_0_HZ));
  localparam logic [HALF_W-1:0] HALF_1 = HALF_W'(REF_CLK_HZ / (2 * RATE_1_HZ));
  localparam logic [HALF_W-1:0] HALF_2 = HALF_W'(REF_CLK_HZ / (2 * RATE_2_HZ));
  localparam logic [HALF_W-1:0] HALF_3 = HALF_W'(REF_CLK_HZ / (2 * RATE_3_HZ));
endpackage

// *** tb/bus_peer.sv ***
// peer model on the serial pins: a bus master driving clock and data, both lines pulled up
// assumes the bench calls its tasks in order and the block may stretch the clock by pulling it low
`timescale 1ns/100ps
module bus_peer (
  input wire logic scl_o,
  input wire logic scl_oe,
  input wire logic sda_o,
  input wire logic sda_oe,
  output logic scl_i,
  output logic sda_i
);
  logic scl_q = 1'b1;
  logic sda_q = 1'b1;
  int hung = 0;
  // wired-and: a released line floats to the pull-up level
  assign scl_i = scl_q & ~(scl_oe & ~scl_o);
  assign sda_i = sda_q & ~(sda_oe & ~sda_o);
  // the odd 1.3 ns keeps pin edges off the ref_clk edges
  task automatic start_c();
    #1.3 sda_q = 1'b0;
    #62.5 scl_q = 1'b0;
  endtask
  task automatic stop_c();
    #1.3 sda_q = 1'b0;
    #62.5 scl_q = 1'b1;
    #62.5 sda_q = 1'b1;
  endtask
  // msb first; a 1 leaves data released so the block can acknowledge
  task automatic send(input logic [7:0] d, input int n);
    int t;
    #1.3;
    for (int i = n - 1; i >= 0; i--) begin
      #20 sda_q = d[i];
      #42.5 scl_q = 1'b1;
      t = 0;
      while (!scl_i && t < 30000) begin
        #1 t = t + 1;
      end
      if (t >= 30000) hung++;
      #62.5 scl_q = 1'b0;
    end
  endtask
endmodule // bus_peer

// *** tb/serial_if0_wait_status_ctrl_tb.sv ***
// bench for serial interface 0 control: register port, waits, clock-count flags, events, shift rate
// assumes the peer model on the pins; the block's assertions live in its own files
`timescale 1ns/100ps
module serial_if0_wait_status_ctrl_tb;
  import serial0_pkg::*;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic clock_stop_rst = 1'b0;
  logic ce_rst = 1'b0;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [DATA_W-1:0] reg_wdata = '0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [DATA_W-1:0] reg_rdata;
  logic irq, scl_i, scl_o, scl_oe, sda_i, sda_o, sda_oe;
  int errors = 0;
  int total_checks = 0;
  int cyc = 0;
  initial begin
    forever #4 ref_clk = ~ref_clk;
  end
  serial0_ctrl dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .clock_stop_rst(clock_stop_rst), .ce_rst(ce_rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .irq(irq), .scl_i(scl_i), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe));
  bus_peer peer (.scl_o(scl_o), .scl_oe(scl_oe), .sda_o(sda_o), .sda_oe(sda_oe), .scl_i(scl_i), .sda_i(sda_i));
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // ceiling well above the roughly 8k cycles the tests need
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 60000) begin
      errors++;
      final_report();
    end
  end
  task automatic check_reg(input logic [3:0] got, input logic [3:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic check_bit(input logic got, input logic exp);
    check_reg({3'h0, got}, {3'h0, exp});
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [3:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic expect_reg(input logic [ADDR_W-1:0] a, input logic [3:0] exp);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 check_reg(reg_rdata, exp);
  endtask
  // pins pass a two-flop synchroniser, flags follow three cycles after a pin edge, the eighth and ninth clock flags four
  // ends just off the edge so outputs are read settled, not in the step that launches them
  task automatic settle();
    repeat (8) @(posedge ref_clk);
    #1;
  endtask
  // watches the pin level, so push-pull and open-drain clocking look alike
  task automatic wait_fall(output int n);
    logic prev;
    n = 0;
    prev = scl_i;
    do begin
      @(posedge ref_clk);
      #1;
      n++;
      if (prev && !scl_i) break;
      prev = scl_i;
    end while (n < 8000);
  endtask
  task automatic test_regs();
    check_bit(irq, 1'b0);
    expect_reg(ADDR_WAIT_CONTROL, 4'h0);
    expect_reg(ADDR_WAIT_STATUS, 4'h0);
    expect_reg(ADDR_CLOCK_COUNT_STATUS, 4'h0);
    expect_reg(6'h3f, 4'h0);
    wr(ADDR_WAIT_STATUS, 4'hf);
    expect_reg(ADDR_WAIT_STATUS, 4'h0);
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_INTERRUPT_POINT, 4'(i));
      expect_reg(ADDR_INTERRUPT_POINT, 4'(i));
    end
    wr(ADDR_MODE, 4'he);
    expect_reg(ADDR_MODE, 4'he);
    $display("test regs done");
  endtask
  task automatic test_bus();
    wr(ADDR_MODE, 4'h4);
    wr(ADDR_INTERRUPT_POINT, {2'h0, IRQ_AT_7});
    wr(ADDR_EVENT_MASK, 4'h2);
    wr(ADDR_WAIT_CONTROL, {2'h0, WAIT_AFTER_8});
    peer.start_c();
    settle();
    expect_reg(ADDR_CLOCK_COUNT_STATUS, 4'h3);
    peer.send(8'ha5, 8);
    settle();
    check_bit(scl_oe & ~scl_o, 1'b1);
    check_bit(sda_oe, 1'b1);
    check_bit(sda_o, 1'b0);
    check_bit(irq, 1'b1);
    expect_reg(ADDR_WAIT_STATUS, 4'h0);
    expect_reg(ADDR_CLOCK_COUNT_STATUS, 4'hb);
    expect_reg(ADDR_EVENT_STATUS, 4'h7);
    settle();
    check_bit(irq, 1'b0);
    wr(ADDR_WAIT_CONTROL, {2'h0, WAIT_AFTER_8});
    settle();
    expect_reg(ADDR_WAIT_STATUS, 4'h1);
    check_bit(scl_oe, 1'b0);
    peer.send(8'hff, 1);
    settle();
    expect_reg(ADDR_CLOCK_COUNT_STATUS, 4'hd);
    expect_reg(ADDR_WAIT_CONTROL, {2'h0, WAIT_AFTER_8});
    peer.stop_c();
    settle();
    check_bit(irq, 1'b0);
    expect_reg(ADDR_CLOCK_COUNT_STATUS, 4'h0);
    expect_reg(ADDR_EVENT_STATUS, 4'h8);
    $display("test bus done");
  endtask
  // ack level 1 here so only the wait logic can pull a line low
  task automatic test_waits();
    logic [3:0] ctl [5] = '{4'h8, 4'h9, 4'ha, 4'hb, 4'he};
    logic [4:0] w8 = 5'b01010;
    logic [4:0] w9 = 5'b00100;
    logic [1:0] pt;
    wr(ADDR_EVENT_MASK, 4'h1);
    for (int i = 0; i < 5; i++) begin
      pt = 2'(i);
      wr(ADDR_INTERRUPT_POINT, {2'h0, pt});
      wr(ADDR_WAIT_CONTROL, ctl[i]);
      peer.start_c();
      peer.send(8'h5a, 7);
      settle();
      check_bit(irq, pt == IRQ_AT_7 || pt == IRQ_AT_7_AFTER_START);
      peer.send(8'h5a, 1);
      settle();
      check_bit(irq, pt != IRQ_AT_STOP);
      check_bit(scl_oe, w8[i]);
      if (w8[i]) wr(ADDR_WAIT_CONTROL, ctl[i]);
      // peer holds data low on the ninth clock in even passes
      peer.send(8'(i % 2), 1);
      settle();
      check_bit(scl_oe, w9[i]);
      if (w9[i]) wr(ADDR_WAIT_CONTROL, ctl[i]);
      expect_reg(ADDR_WAIT_CONTROL, {1'(i % 2), ctl[i][2:0]});
      peer.stop_c();
      settle();
      check_bit(irq, 1'b1);
      expect_reg(ADDR_EVENT_STATUS, {2'h3, w8[i] | w9[i], 1'b1});
    end
    $display("test waits done");
  endtask
  task automatic test_rates();
    int p;
    logic [HALF_W-1:0] h;
    for (int i = 0; i < 4; i++) begin
      h = (i == 0) ? HALF_0 : (i == 1) ? HALF_1 : (i == 2) ? HALF_2 : HALF_3;
      wr(ADDR_SHIFT_RATE_SELECT, 4'(i));
      // odd passes use the open-drain two-wire internal clock
      wr(ADDR_MODE, (i % 2) ? 4'h2 : 4'ha);
      wr(ADDR_WAIT_CONTROL, 4'h4);
      wait_fall(p);
      wait_fall(p);
      check_bit(p >= 2 * h - 2 && p <= 2 * h + 2, 1'b1);
      if (i % 2) check_bit(scl_o, 1'b0);
      @(posedge ref_clk);
      clock_stop_rst <= (i < 2);
      ce_rst <= (i >= 2);
      @(posedge ref_clk);
      clock_stop_rst <= 1'b0;
      ce_rst <= 1'b0;
      settle();
      expect_reg(ADDR_SHIFT_RATE_SELECT, 4'(i));
      expect_reg(ADDR_WAIT_CONTROL, 4'h0);
      expect_reg(ADDR_CLOCK_COUNT_STATUS, 4'h0);
      check_bit(scl_oe, 1'b0);
    end
    $display("test rates done");
  endtask
  initial begin
    repeat (16) @(posedge ref_clk);
    sys_rst <= 1'b0;
    test_regs();
    test_bus();
    test_waits();
    test_rates();
    check_bit(peer.hung == 0, 1'b1);
    final_report();
  end
endmodule // serial_if0_wait_status_ctrl_tb
